// *** hdl/mpv_top.v ***
// APB register block for fourteen shared pins
`timescale 1ns/1ns
`include "mpv_defs.vh"
module mpv_top #(
   parameter NPIN = 14
) (
   input  wire              mclk,
   input  wire              rstn,
   input  wire              ce,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [17:0]       paddr,
   input  wire [31:0]       pwdata,
   input  wire [3:0]        pstrb,
   output wire              pready,
   output wire              pslverr,
   output reg  [31:0]       prdata,
   input  wire [NPIN-1:0]   shared_pin,
   output wire [NPIN-1:0]   core_level,
   output wire [NPIN-1:0]   multipurpose_select,
   output wire [3*NPIN-1:0] pin_function_select
);

   // ****************************************
   // Address decode
   // ****************************************
   localparam [15:0] NPIN_W = NPIN;

   wire [15:0] idx     = paddr[17:2];
   wire [15:0] off_out = idx - `MPV_OUT_BASE;
   wire [15:0] off_in  = idx - `MPV_IN_BASE;
   wire [15:0] off_cfg = idx - `MPV_CFG_BASE;
   // Wrap-around makes indices below a base fail the compare as well
   wire        hit_out = off_out < NPIN_W;
   wire        hit_in  = off_in  < NPIN_W;
   wire        hit_cfg = off_cfg < NPIN_W;
   wire        hit     = hit_out | hit_in | hit_cfg;

   // ****************************************
   // APB handshake
   // ****************************************
   // Read data is captured one edge ahead, so the access phase answers
   // at once; with ce low nothing moves and pready stays low.
   reg  cap_r;
   wire acc_done = psel & penable & cap_r & ce;
   wire wr_acc   = acc_done & pwrite & pstrb[0] & hit;

   assign pready  = cap_r & ce;
   assign pslverr = cap_r & ce & ~hit;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         cap_r <= 1'b0;
      else if (ce)
         cap_r <= psel & ~(penable & cap_r);
   end

   // ****************************************
   // Per-pin storage
   // ****************************************
   wire [4*NPIN-1:0] cfg_all;
   wire [NPIN-1:0]   forced_all;
   wire [NPIN-1:0]   sampled_all;

   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1) begin : g_pin
         localparam [15:0] PI = i;
         wire cfg_we = wr_acc & hit_cfg & (off_cfg == PI);
         wire out_we = wr_acc & hit_out & (off_out == PI);
         mpv_pin u_pin (
            .mclk      (mclk),
            .rstn      (rstn),
            .ce        (ce),
            .pin_raw   (shared_pin[i]),
            .cfg_we    (cfg_we),
            .out_we    (out_we),
            .wdata     (pwdata[3:0]),
            .cfg_r     (cfg_all[4*i +: 4]),
            .forced_r  (forced_all[i]),
            .sampled_r (sampled_all[i]),
            .core_r    (core_level[i])
         );
         assign multipurpose_select[i]      = cfg_all[4*i+`MPV_SEL_BIT];
         assign pin_function_select[3*i +: 3] =
            cfg_all[4*i+`MPV_FN_LSB +: 3];
      end
   endgenerate

   // ****************************************
   // Read path
   // ****************************************
   // Writes to input-value indices hit but store nothing
   reg [31:0] rd_nxt;

   always @* begin
      rd_nxt = 32'h0000_0000;
      if (hit_out)
         rd_nxt[`MPV_LEVEL_BIT] = forced_all[off_out[3:0]];
      else if (hit_in)
         rd_nxt[`MPV_LEVEL_BIT] = sampled_all[off_in[3:0]];
      else if (hit_cfg)
         rd_nxt[3:0] = cfg_all[{off_cfg[3:0], 2'b00} +: 4];
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         prdata <= 32'h0000_0000;
      else if (ce && psel && !cap_r)
         prdata <= rd_nxt;
   end

endmodule

// *** hdl/mpv_defs.vh ***
// Constants for the shared-pin value registers
`ifndef MPV_DEFS_VH
`define MPV_DEFS_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define MPV_OUT_BASE  16'hf520
`define MPV_IN_BASE   16'hf530
`define MPV_CFG_BASE  16'hf510

// ****************************************
// Reset values
// ****************************************
`define MPV_OUT_RST   1'b0
`define MPV_IN_RST    1'b0
`define MPV_CFG_RST   4'h0

// ****************************************
// Field positions
// ****************************************
`define MPV_LEVEL_BIT 0
`define MPV_SEL_BIT   0
`define MPV_FN_MSB    3
`define MPV_FN_LSB    1

// ****************************************
// Function select codes
// ****************************************
`define MPV_FN_GPIN   3'h0
`define MPV_FN_CTRL   3'h1
`define MPV_FN_PDM    3'h4

`endif

// *** hdl/mpv_pin.v ***
// One shared pin: configuration, forced level, sampled level, core level
`timescale 1ns/1ns
`include "mpv_defs.vh"
module mpv_pin (
   input  wire       mclk,
   input  wire       rstn,
   input  wire       ce,
   input  wire       pin_raw,
   input  wire       cfg_we,
   input  wire       out_we,
   input  wire [3:0] wdata,
   output reg  [3:0] cfg_r,
   output reg        forced_r,
   output reg        sampled_r,
   output reg        core_r
);

   // ****************************************
   // Pin synchroniser
   // ****************************************
   reg sync1_r;
   reg sync2_r;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else if (ce) begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   wire [2:0] fn      = cfg_r[`MPV_FN_MSB:`MPV_FN_LSB];
   wire       mp_en   = cfg_r[`MPV_SEL_BIT];
   wire       ctrl_md = mp_en && (fn == `MPV_FN_CTRL);
   wire       in_md   = mp_en && (fn == `MPV_FN_GPIN || fn == `MPV_FN_CTRL
                                  || fn == `MPV_FN_PDM);
   reg        ovr_r;
   reg        core_nxt;

   always @* begin
      core_nxt = 1'b0;
      if (ctrl_md)
         core_nxt = ovr_r ? forced_r : sync2_r;
      else if (in_md)
         core_nxt = sync2_r;
   end

   // ****************************************
   // State
   // ****************************************
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_r     <= `MPV_CFG_RST;
         forced_r  <= `MPV_OUT_RST;
         sampled_r <= `MPV_IN_RST;
         ovr_r     <= 1'b0;
         core_r    <= 1'b0;
      end else if (ce) begin
         if (cfg_we)
            cfg_r <= wdata;
         if (out_we)
            forced_r <= wdata[`MPV_LEVEL_BIT];
         // Override lasts until the pin leaves control-port mode
         if (!ctrl_md)
            ovr_r <= 1'b0;
         else if (out_we)
            ovr_r <= 1'b1;
         // Held value survives leaving input mode; primary use ignores it
         if (in_md)
            sampled_r <= sync2_r;
         core_r <= core_nxt;
      end
   end

endmodule

// *** tb/mpv_pins.sv ***
// Model of the external levels on the shared pins
`timescale 1ns/1ns
module mpv_pins (
   input  wire        mclk,
   input  wire [13:0] want,
   output reg  [13:0] shared_pin
);
   // Pins always driven, so no floating level reaches the synchroniser
   always @(posedge mclk) shared_pin <= want;
endmodule

// *** tb/mpv_top_props.sv ***
// Concurrent checks on the shared-pin block ports
`timescale 1ns/1ns
module mpv_top_props #(parameter NPIN = 14) (
   input wire              mclk,
   input wire              rstn,
   input wire              psel,
   input wire              penable,
   input wire              pwrite,
   input wire [17:0]       paddr,
   input wire              pready,
   input wire              pslverr,
   input wire [31:0]       prdata,
   input wire [NPIN-1:0]   shared_pin,
   input wire [NPIN-1:0]   core_level,
   input wire [NPIN-1:0]   multipurpose_select,
   input wire [3*NPIN-1:0] pin_function_select
);
   wire [15:0] idx = paddr[17:2];
   wire        rok = pready && !pwrite && !pslverr;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_gpin0; multipurpose_select[0] && !pin_function_select[2:0];
   endsequence
   a_setup_ready: assert property (s_setup |=> pready)
      else $error("late ready");
   a_ready_once: assert property (pready |=> !pready)
      else $error("long ready");
   a_err_zero: assert property (pslverr && !pwrite |-> !prdata)
      else $error("error read data");
   a_upper_zero: assert property (rok |-> !prdata[31:4])
      else $error("upper bits");
   a_level_bit: assert property (rok && idx >= 16'hf520 &&
      idx <= 16'hf53d |-> !prdata[31:1]) else $error("level bit");
   a_in_mapped: assert property (pready && idx[15:4] == 12'hf53 &&
      idx[3:0] <= 4'hd |-> !pslverr) else $error("input error");
   a_gpin_path: assert property (s_gpin0 [*4] |->
      core_level[0] == $past(shared_pin[0], 3)) else $error("pin path");
   a_off_low: assert property (!$past(multipurpose_select[0]) |->
      !core_level[0]) else $error("disabled pin");
endmodule
bind mpv_top mpv_top_props #(.NPIN(NPIN)) i_mpv_top_props (.mclk, .rstn,
   .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata,
   .shared_pin, .core_level, .multipurpose_select, .pin_function_select);

// *** tb/tb_mpv_top.sv ***
// Self-checking bench for the shared-pin register block
`timescale 1ns/1ns
module tb_mpv_top;
   logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic        ce = 1;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [13:0] want = 0;
   wire         pready, pslverr;
   wire [31:0]  prdata;
   wire [13:0]  shared_pin, core_level, multipurpose_select;
   wire [41:0]  pin_function_select;
   int          fails = 0, compares = 0, seed = 32'h1c15, i, v;
   int          outv[14];
   always #5 mclk = ~mclk;
   mpv_pins i_pins (.mclk, .want, .shared_pin);
   mpv_top i_mpv_top (.mclk, .rstn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb(4'hf), .pready, .pslverr, .prdata,
      .shared_pin, .core_level, .multipurpose_select, .pin_function_select);
   task chk(string n, logic [31:0] s, logic [31:0] x);
      compares++;
      if (s !== x) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   task conclude;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Starts on a rising edge so back-to-back calls never share a step
   task apb(bit w, int x, logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {x[15:0], 2'b00};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      // Ready, error and data are all taken at the completing rising edge
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         fails++;
         conclude;
      end
      e = pslverr;
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1;
      for (i = 0; i < 14; i++) begin
         apb(0, 'hf520 + i, 0);
         chk("out reset", rd, 0);
         apb(0, 'hf530 + i, 0);
         chk("in reset", rd, 0);
      end
      apb(0, 'hf540, 0);
      chk("unmapped", e, 1);
      chk("unmapped data", rd, 0);
      for (i = 0; i < 14; i++) begin
         v = $random(seed);
         @(posedge mclk);
         want[i] <= v[0];
         apb(1, 'hf510 + i, 1);
         repeat (4) @(posedge mclk);
         apb(0, 'hf530 + i, 0);
         chk("in level", rd, v & 1);
         apb(1, 'hf530 + i, ~v);
         apb(0, 'hf530 + i, 0);
         chk("in ro", rd, v & 1);
         apb(1, 'hf510 + i, 3);
         repeat (2) @(negedge mclk);
         chk("core fwd", core_level[i], v & 1);
         chk("select out", multipurpose_select[i], 1);
         chk("function out", pin_function_select[3*i +: 3], 1);
         apb(0, 'hf510 + i, 0);
         chk("cfg read", rd, 3);
         outv[i] = ~v & 1;
         apb(1, 'hf520 + i, ~v);
         apb(0, 'hf520 + i, 0);
         chk("out bit", rd, outv[i]);
         chk("core forced", core_level[i], outv[i]);
         apb(1, 'hf510 + i, 1);
         repeat (2) @(negedge mclk);
         chk("core pin", core_level[i], v & 1);
         apb(1, 'hf510 + i, 0);
         repeat (2) @(negedge mclk);
         chk("core off", core_level[i], 0);
      end
      // Freeze with the bus idle: a pin change must wait for ce
      apb(1, 'hf51d, 1);
      want[13] <= 1;
      repeat (4) @(posedge mclk);
      ce <= 0;
      want[13] <= 0;
      repeat (4) @(posedge mclk);
      chk("frozen core", core_level[13], 1);
      ce <= 1;
      repeat (4) @(posedge mclk);
      chk("thawed core", core_level[13], 0);
      conclude;
   end
endmodule
